// [logic/hdfo_core.sv]
// Format override, framing indications and external word clock pin control
`timescale 1ns/10ps
module hdfo_core
  import hdfo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] ancillary_port_in,
  input wire logic port_ctrl_sel,
  input wire logic port_wr,
  input wire logic [7:0] port_addr,
  output logic [9:0] ancillary_port_out,
  output logic ancillary_port_oe,
  input wire logic det_hd,
  input wire logic [4:0] det_subfmt,
  input wire logic lock_detect,
  input wire logic [LUMA_W-1:0] luma_in,
  input wire logic [CHROMA_W-1:0] chroma_in,
  input wire logic word_valid,
  input wire logic trs_eav,
  input wire logic trs_sav,
  input wire logic crc_error_in,
  input wire logic anc_packet_in,
  output logic [LUMA_W-1:0] luma_out,
  output logic [CHROMA_W-1:0] chroma_out,
  output logic eav_flag,
  output logic sav_flag,
  output logic [LINE_W-1:0] line_number,
  output logic crc_error,
  output logic anc_fifo_push,
  output logic hd_mode,
  output logic [4:0] active_subfmt,
  output logic auto_detect_en,
  output logic [IO_W-1:0] io_port,
  input wire logic video_word_clock_in,
  output logic video_word_clock_out,
  output logic video_word_clock_oe,
  output logic bias_resistor_pin_is_cv,
  output logic pfd_enable,
  output logic pfd_up,
  output logic pfd_down
);
  logic [7:0] fmt_reg;
  logic [7:0] vid_reg;
  logic [7:0] rd_data;
  logic ctrl_write;
  logic addr_fmt;
  logic addr_vid;
  logic addr_hit;
  logic hd_restrict_bit;
  logic [4:0] fmt_sel;
  logic general_hd;
  logic ext_vcxo_enable;
  logic framing_on;
  logic [9:0] port_word;
  hdfo_state_t state_q, state_d;
  logic [LINE_W-1:0] line_q, line_d;
  logic eav_q, sav_q, crc_q, push_q;
  logic [LUMA_W-1:0] luma_q;
  logic [CHROMA_W-1:0] chroma_q;
  logic video_word_clock_q;
  logic ref_s1_q, ref_s2_q, ref_prev_q;
  logic ref_rise;
  logic int_rise;
  logic eav_d, sav_d, crc_d, push_d;
  logic in_frame;
  logic pfd_up_d, pfd_down_d;
  logic pfd_up_q, pfd_down_q;
  logic video_word_clock_drive;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  function automatic logic prefix_ok(input logic [9:0] w);
    return w[9:8] == CTRL_PREFIX;
  endfunction

  assign addr_fmt = addr_is(port_addr, FORMAT_CONFIG_ADDR);
  assign addr_vid = addr_is(port_addr, VIDEO_CONTROL_PRIMARY_ADDR);
  assign addr_hit = addr_fmt | addr_vid;
  assign port_word = ancillary_port_in;
  // Control word only taken with the 11 prefix on the top bits
  // A wrong prefix is dropped silently, nothing answers on the port
  assign ctrl_write = port_ctrl_sel && port_wr && addr_hit
                      && prefix_ok(port_word);

  hdfo_regfile u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(ctrl_write),
    .wr_idx(addr_vid),
    .wr_data(port_word[7:0]),
    .rd_idx(addr_vid),
    .rd_data(rd_data),
    .reg0(fmt_reg),
    .reg1(vid_reg)
  );

  // Read back drives the port with prefix, otherwise port floats
  assign ancillary_port_oe = port_ctrl_sel && !port_wr && addr_hit;
  assign ancillary_port_out = {CTRL_PREFIX, rd_data};

  assign hd_restrict_bit = fmt_reg[HD_RESTRICT_POS];
  assign fmt_sel = fmt_reg[FMT_SEL_LSB +: FMT_SEL_W];
  assign auto_detect_en = !hd_restrict_bit;
  assign hd_mode = hd_restrict_bit | det_hd;
  assign active_subfmt = hd_restrict_bit ? fmt_sel : det_subfmt;
  assign general_hd = hd_restrict_bit && fmt_sel == GENERAL_HD_CODE;
  assign framing_on = !general_hd;

  // Line tracking follows timing reference words
  always_comb begin
    state_d = state_q;
    line_d = line_q;
    case (state_q)
      HDFO_HUNT: begin
        if (framing_on && word_valid && trs_sav) begin
          state_d = HDFO_ACTIVE;
          line_d = LINE_ONE;
        end
      end
      HDFO_ACTIVE: begin
        if (!framing_on) begin
          state_d = HDFO_HUNT;
        end else if (word_valid && trs_eav) begin
          state_d = HDFO_BLANK;
        end
      end
      HDFO_BLANK: begin
        if (!framing_on) begin
          state_d = HDFO_HUNT;
        end else if (word_valid && trs_sav) begin
          state_d = HDFO_ACTIVE;
          line_d = line_q + LINE_ONE;
        end
      end
      default: state_d = HDFO_HUNT;
    endcase
    if (!framing_on) begin
      line_d = LINE_RST;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HDFO_HUNT;
      line_q <= LINE_RST;
    end else begin
      state_q <= state_d;
      line_q <= line_d;
    end
  end

  // Framing qualifiers, all gated off while general HD is forced
  assign in_frame = state_q != HDFO_HUNT;
  assign eav_d = framing_on && word_valid && trs_eav;
  assign sav_d = framing_on && word_valid && trs_sav;
  assign crc_d = framing_on && word_valid && crc_error_in;
  // Packets only extracted once a line start has been seen
  assign push_d = framing_on && word_valid && anc_packet_in && in_frame;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eav_q <= 1'b0;
      sav_q <= 1'b0;
      crc_q <= 1'b0;
      push_q <= 1'b0;
    end else begin
      eav_q <= eav_d;
      sav_q <= sav_d;
      crc_q <= crc_d;
      push_q <= push_d;
    end
  end

  // Samples still pass word aligned whatever the framing state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      luma_q <= '0;
      chroma_q <= '0;
    end else if (word_valid) begin
      luma_q <= luma_in;
      chroma_q <= chroma_in;
    end
  end

  assign eav_flag = eav_q;
  assign sav_flag = sav_q;
  assign crc_error = crc_q;
  assign anc_fifo_push = push_q;
  assign line_number = line_q;
  assign luma_out = luma_q;
  assign chroma_out = chroma_q;

  // Word clock: internal toggle every clk, data registers follow word_valid whatever its phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      video_word_clock_q <= 1'b0;
    end else begin
      video_word_clock_q <= !video_word_clock_q;
    end
  end
  // Internal edge marked while video_word_clock_q is low, the clk before it rises
  assign int_rise = !video_word_clock_q;

  assign ext_vcxo_enable = vid_reg[EXT_VCXO_POS];
  assign pfd_enable = ext_vcxo_enable;
  assign bias_resistor_pin_is_cv = ext_vcxo_enable;
  assign video_word_clock_oe = !ext_vcxo_enable;

  // Output side of the word clock pin parks low once the pin is an input
  assign video_word_clock_drive = ext_vcxo_enable ? 1'b0 : video_word_clock_q;
  assign video_word_clock_out = video_word_clock_drive;

  // External VCXO edge, synchronised before comparison
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      ref_s1_q <= video_word_clock_in;
      ref_s2_q <= ref_s1_q;
      ref_prev_q <= ref_s2_q;
    end
  end
  assign ref_rise = ref_s2_q && !ref_prev_q;

  // Phase detector pulses steer the VCXO towards the word rate
  assign pfd_up_d = ext_vcxo_enable && int_rise && !ref_rise;
  assign pfd_down_d = ext_vcxo_enable && ref_rise && !int_rise;

  // Pulses leave from flops so the control voltage pin sees no glitches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pfd_up_q <= 1'b0;
      pfd_down_q <= 1'b0;
    end else begin
      pfd_up_q <= pfd_up_d;
      pfd_down_q <= pfd_down_d;
    end
  end

  assign pfd_up = pfd_up_q;
  assign pfd_down = pfd_down_q;

  // Power-on mapping of status onto the I/O port, other bits held low
  genvar b;
  generate
    for (b = 0; b < IO_W; b++) begin : g_io
      if (b == IO_FMT_HD_POS) begin : g_fmt
        assign io_port[b] = hd_mode;
      end else if (b == IO_LOCK_POS) begin : g_lock
        assign io_port[b] = lock_detect;
      end else begin : g_zero
        assign io_port[b] = 1'b0;
      end
    end
  endgenerate
endmodule

// [logic/hdfo_pkg.sv]
// Constants and types shared by the format override and external clock block
package hdfo_pkg;
  localparam logic [7:0] FORMAT_CONFIG_ADDR = 8'h0b;
  localparam logic [7:0] VIDEO_CONTROL_PRIMARY_ADDR = 8'h55;
  localparam logic [7:0] FORMAT_CONFIG_RST = 8'h00;
  localparam logic [7:0] VIDEO_CONTROL_PRIMARY_RST = 8'h00;
  localparam int HD_RESTRICT_POS = 5;
  localparam int FMT_SEL_LSB = 0;
  localparam int FMT_SEL_W = 5;
  localparam int EXT_VCXO_POS = 0;
  localparam logic [1:0] CTRL_PREFIX = 2'b11;
  localparam logic [4:0] GENERAL_HD_CODE = 5'h1f;
  localparam logic [9:0] FORCE_HD_WORD = 10'h33f;
  localparam int IO_FMT_HD_POS = 3;
  localparam int IO_LOCK_POS = 4;
  localparam int IO_W = 8;
  localparam int LUMA_W = 10;
  localparam int CHROMA_W = 10;
  localparam int LINE_W = 11;
  localparam logic [LINE_W-1:0] LINE_RST = 11'h000;
  localparam logic [LINE_W-1:0] LINE_ONE = 11'h001;
  localparam int REG_DEPTH = 2;
  typedef enum logic [1:0] {HDFO_HUNT, HDFO_ACTIVE, HDFO_BLANK} hdfo_state_t;
endpackage

// [logic/hdfo_regfile.sv]
// Small register store for the two control registers, registered read data
`timescale 1ns/10ps
module hdfo_regfile
  import hdfo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [0:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [0:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [7:0] reg0,
  output logic [7:0] reg1
);
  logic [7:0] mem_q [REG_DEPTH];

  genvar g;
  generate
    for (g = 0; g < REG_DEPTH; g++) begin : g_reg
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[g] <= (g == 0) ? FORMAT_CONFIG_RST : VIDEO_CONTROL_PRIMARY_RST;
        end else if (wr_en && wr_idx == 1'(g)) begin
          mem_q[g] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_q[rd_idx];
    end
  end

  assign reg0 = mem_q[0];
  assign reg1 = mem_q[1];
endmodule

// [verif/hdfo_checker.sv]
// Assertion checker for the format override block
`timescale 1ns/10ps
module hdfo_checker
  import hdfo_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic port_ctrl_sel,
  input logic port_wr,
  input logic [7:0] port_addr,
  input logic [9:0] ancillary_port_in,
  input logic word_valid,
  input logic [9:0] luma_in,
  input logic [9:0] luma_out,
  input logic eav_flag,
  input logic sav_flag,
  input logic crc_error,
  input logic anc_fifo_push,
  input logic hd_mode,
  input logic [4:0] active_subfmt,
  input logic auto_detect_en,
  input logic [IO_W-1:0] io_port,
  input logic lock_detect,
  input logic pfd_enable,
  input logic bias_resistor_pin_is_cv,
  input logic video_word_clock_oe,
  input logic video_word_clock_out,
  input logic pfd_up,
  input logic pfd_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire frc = !auto_detect_en && active_subfmt == GENERAL_HD_CODE;
  wire wr33 = port_ctrl_sel && port_wr && port_addr == FORMAT_CONFIG_ADDR
    && ancillary_port_in == FORCE_HD_WORD;
  property p_force; wr33 |=> frc && hd_mode; endproperty
  a_force: assert property (p_force) else $error("force word ignored");
  property p_only; !auto_detect_en |-> hd_mode; endproperty
  a_only: assert property (p_only) else $error("hd_restrict_bit not kept");
  property p_trs; $past(frc) |-> !eav_flag && !sav_flag; endproperty
  a_trs: assert property (p_trs) else $error("timing flag in forced mode");
  property p_trk; $past(frc) |-> !crc_error && !anc_fifo_push; endproperty
  a_trk: assert property (p_trk) else $error("tracking in forced mode");
  property p_word; word_valid |=> luma_out == $past(luma_in); endproperty
  a_word: assert property (p_word) else $error("word not passed");
  property p_hold; !word_valid |=> $stable(luma_out); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_io;
    io_port[IO_FMT_HD_POS] == hd_mode && io_port[IO_LOCK_POS] == lock_detect;
  endproperty
  a_io: assert property (p_io) else $error("status bits wrong");
  property p_ext;
    pfd_enable == bias_resistor_pin_is_cv && pfd_enable != video_word_clock_oe;
  endproperty
  a_ext: assert property (p_ext) else $error("pin roles wrong");
  property p_pfd; !pfd_enable && !$past(pfd_enable) |-> !pfd_up && !pfd_down; endproperty
  a_pfd: assert property (p_pfd) else $error("detector active while off");
  property p_video_word_clock;
    $past(rst_n) && video_word_clock_oe && $past(video_word_clock_oe)
      |-> video_word_clock_out != $past(video_word_clock_out);
  endproperty
  a_video_word_clock: assert property (p_video_word_clock) else $error("word clock not toggling");
  c_force: cover property (wr33);
  c_pfd: cover property (pfd_up);
  c_ext: cover property ($rose(pfd_enable));
  c_vid: cover property (frc && word_valid);
endmodule

// [verif/hdfo_core_bench.sv]
// Directed bench for the format override and external clock block
`timescale 1ns/10ps
module hdfo_core_bench
  import hdfo_pkg::*;
;
  logic clk, rst_n, port_ctrl_sel, port_wr, det_hd, lock_detect, word_valid;
  logic trs_eav, trs_sav, crc_error_in, anc_packet_in, video_word_clock_in;
  logic ancillary_port_oe, eav_flag, sav_flag, crc_error, anc_fifo_push, hd_mode;
  logic auto_detect_en, video_word_clock_out, video_word_clock_oe;
  logic bias_resistor_pin_is_cv, pfd_enable, pfd_up, pfd_down;
  logic [9:0] ancillary_port_in, ancillary_port_out, luma_in, luma_out;
  logic [9:0] chroma_in, chroma_out;
  logic [7:0] port_addr;
  logic [4:0] det_subfmt, active_subfmt;
  logic [LINE_W-1:0] line_number;
  logic [IO_W-1:0] io_port;
  int fail_count = 0;
  int n_tests = 0;
  hdfo_core DUT (.*);
  hdfo_vcxo_sel vcxo (.io_port(io_port), .vcxo_clk(video_word_clock_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [9:0] d);
    @(negedge clk);
    {port_ctrl_sel, port_wr, port_addr, ancillary_port_in} = {2'b11, a, d};
    @(negedge clk);
    {port_ctrl_sel, port_wr} = 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic oe);
    @(negedge clk);
    {port_ctrl_sel, port_addr} = {1'b1, a};
    @(negedge clk);
    chk(ancillary_port_oe, oe);
    if (oe) chk(ancillary_port_out, {CTRL_PREFIX, e});
    port_ctrl_sel = 1'b0;
  endtask
  task automatic vid(input logic [9:0] l, input logic [3:0] q, input logic [3:0] e);
    @(negedge clk);
    {word_valid, luma_in, chroma_in} = {1'b1, l, ~l};
    {trs_eav, trs_sav, crc_error_in, anc_packet_in} = q;
    @(negedge clk);
    {word_valid, trs_eav, trs_sav, crc_error_in, anc_packet_in} = 5'h00;
    chk({luma_out, chroma_out}, {l, ~l});
    chk({eav_flag, sav_flag, crc_error, anc_fifo_push}, e);
  endtask
  initial begin
    {rst_n, port_ctrl_sel, port_wr, word_valid, trs_eav, trs_sav} = 6'h00;
    {crc_error_in, anc_packet_in, det_hd, lock_detect} = 4'h3;
    {port_addr, ancillary_port_in, luma_in, chroma_in} = 38'h0;
    det_subfmt = 5'h05;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk({auto_detect_en, video_word_clock_oe}, 2'b11);
    chk(active_subfmt, 5'h05);
    rd(FORMAT_CONFIG_ADDR, FORMAT_CONFIG_RST, 1'b1);
    rd(VIDEO_CONTROL_PRIMARY_ADDR, VIDEO_CONTROL_PRIMARY_RST, 1'b1);
    rd(8'h12, 8'h00, 1'b0);
    chk(io_port[4:3], 2'b11);
    lock_detect = 1'b0;
    @(negedge clk);
    chk(io_port[4:3], 2'b01);
    vid(10'h2a5, 4'h4, 4'h4);
    chk(line_number, LINE_ONE);
    vid(10'h155, 4'h3, 4'h3);
    vid(10'h0aa, 4'h8, 4'h8);
    vid(10'h3c3, 4'h4, 4'h4);
    chk(line_number, LINE_ONE + LINE_ONE);
    wr(FORMAT_CONFIG_ADDR, 10'h23f);
    rd(FORMAT_CONFIG_ADDR, 8'h00, 1'b1);
    det_hd = 1'b0;
    wr(FORMAT_CONFIG_ADDR, FORCE_HD_WORD);
    chk({hd_mode, auto_detect_en, active_subfmt}, {2'b10, GENERAL_HD_CODE});
    rd(FORMAT_CONFIG_ADDR, 8'h3f, 1'b1);
    for (int i = 0; i < 4; i++) vid({6'h10, 4'(i)}, 4'h8 >> i, 4'h0);
    chk(line_number, LINE_RST);
    wr(VIDEO_CONTROL_PRIMARY_ADDR, 10'h301);
    chk({pfd_enable, bias_resistor_pin_is_cv, video_word_clock_oe}, 3'b110);
    rd(VIDEO_CONTROL_PRIMARY_ADDR, 8'h01, 1'b1);
    lock_detect = 1'b1;
    repeat (20) @(negedge clk);
    print_verdict();
  end
  initial begin
    #20000;
    fail_count++;
    print_verdict();
  end
endmodule
bind hdfo_core hdfo_checker chk_i (.*);

// [verif/hdfo_vcxo_sel.sv]
// Dual VCXO selection logic feeding the word clock pin
`timescale 1ns/10ps
module hdfo_vcxo_sel
  import hdfo_pkg::*;
(
  input logic [IO_W-1:0] io_port,
  output logic vcxo_clk
);
  logic clk_hd = 1'b0;
  logic clk_sd = 1'b0;
  always #6.734 clk_hd = !clk_hd;
  always #18.519 clk_sd = !clk_sd;
  wire sel_hd = io_port[IO_LOCK_POS] & io_port[IO_FMT_HD_POS];
  assign vcxo_clk = sel_hd ? clk_hd : clk_sd;
endmodule
